/* analog_trim_register_bank_tb.sv */
/* self-checking bench: random and corner frames, resets, filter delay.
   assumes atb_spi_master drives the link at 4 core cycles a phase. */
`timescale 1ns/1ps
module analog_trim_register_bank_tb;
  localparam int LIM[4] = '{40, 30, 20, 10};
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        spiSclk, spiSsN, spiMosi, spiMiso, spiMisoOe, ocOut;
  logic [7:0]  statusByte = 8'h00;
  logic        supplyOcRaw = 1'b0;
  logic [1:0]  sel, low, eSel, eLow;
  logic [3:0]  refT, eRef;
  logic [2:0]  up, eUp;
  logic [7:0]  d;
  logic [15:0] rx;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed = 32'hcf82fa6d;
  always #4 core_clk = ~core_clk;
  atb_trim_bank #(.OC_CYC0(LIM[0]), .OC_CYC1(LIM[1]),
    .OC_CYC2(LIM[2]), .OC_CYC3(LIM[3])) uut (
    .core_clk(core_clk), .rst(rst), .spiSclk(spiSclk),
    .spiSsN(spiSsN), .spiMosi(spiMosi), .statusByte(statusByte),
    .supplyOcRaw(supplyOcRaw), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .supplyOcFilterSel(sel),
    .refCurrentTrim(refT), .lowerPairTrim(low),
    .upperPairTrim(up), .supplyOcShutdown(ocOut));
  atb_spi_master mst (.core_clk(core_clk), .spiMiso(spiMiso),
    .spiSclk(spiSclk), .spiSsN(spiSsN), .spiMosi(spiMosi));
  // --------
  // checking helpers
  // --------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] rdExp(input logic [4:0] a);
    return (a == 5'h0F) ? {eSel, 6'h00} : 8'h00;
  endfunction
  task automatic frame(input logic [4:0] a, input logic rw,
      input logic [7:0] dd, input int e, input logic bp);
    logic [15:0] exp;
    logic [10:0] trimExp;
    statusByte = 8'($random(seed));
    exp = {statusByte, rdExp(a)};
    mst.xfer(a, rw, dd, e, bp, rx);
    if (e == 16) chk(rx, exp);
    if (!rw && !bp && e == 16 && a == 5'h0F) begin
      eSel = dd[7:6];
      eRef = dd[3:0];
    end
    if (!rw && !bp && e == 16 && a == 5'h10) begin
      eLow = dd[7:6];
      eUp = dd[5:3];
    end
    trimExp = {eSel, eRef, eLow, eUp};
    chk(16'({sel, refT, low, up}), 16'(trimExp));
  endtask
  function automatic logic [2:0] upCode(input int i);
    return (i % 8 == 4) ? 3'h7 : 3'(i); // code 4 is reserved
  endfunction
  initial begin
    repeat (12) @(posedge core_clk);
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      {eSel, eRef, eLow, eUp} = 11'h000;
      chk(16'({sel, refT, low, up}), 16'h0000);
      chk(16'({spiMisoOe, ocOut}), 16'h0000);
      for (int f = 0; f < 3; f++) begin
        d = 8'($random(seed)) & 8'hC8;
        frame(5'h0F + 5'(f), 1'b0, d, 16, 1'b0);
      end
    end
    for (int i = 0; i < 9; i++) begin
      frame(5'h0F, 1'b0, {2'(i), 2'h0, 4'(i)}, 16, 1'b0);
      frame(5'h10, 1'b0, {2'(i), upCode(i), 3'h0}, 16, 1'b0);
    end
    for (int n = 0; n < 24; n++) begin
      d = 8'($random(seed));
      d[3:0] = 4'($unsigned($random(seed)) % 9);
      // reference trim keeps its defined codes; trim1 reserved bits stay clear, upper trim skips code 4
      if (n % 2 == 0) begin
        d[5:4] = 2'h0;
      end else begin
        d[5:3] = upCode(d[5:3]);
      end
      frame(5'h0F + 5'(n % 2), 1'(n / 3), d, 16, 1'b0);
    end
    frame(5'h0E, 1'b1, 8'h00, 16, 1'b0);
    frame(5'h0F, 1'b0, 8'h45, 15, 1'b0);
    frame(5'h10, 1'b0, 8'h28, 17, 1'b0);
    frame(5'h0F, 1'b0, 8'h83, 16, 1'b1);
    frame(5'h10, 1'b1, 8'hE8, 16, 1'b0);
    for (int s = 0; s < 4; s++) begin
      frame(5'h0F, 1'b0, {2'(s), 6'h00}, 16, 1'b0);
      supplyOcRaw = 1'b1;
      repeat (LIM[s] - 3) @(negedge core_clk);
      supplyOcRaw = 1'b0;
      @(negedge core_clk);
      supplyOcRaw = 1'b1;
      repeat (LIM[s] - 1) @(negedge core_clk);
      chk(16'(ocOut), 16'h0000);
      repeat (1) @(negedge core_clk);
      chk(16'(ocOut), 16'h0001);
      supplyOcRaw = 1'b0;
      repeat (3) @(negedge core_clk);
      chk(16'(ocOut), 16'h0000);
    end
    tally_and_finish();
  end
endmodule

/* atb_params.svh */
/*
 * Constants of the analog trim register bank: register addresses, field
 * positions, reset values and overcurrent filter timing.
 * Assumes a 125 MHz core clock and a 16-edge serial frame.
 */
// Notes on behaviour
// - Two-bit field selects overcurrent filter delay 950/536/234/78 us.
// - Reset clears filter select to 00, the longest delay.
// - Four-bit write-only reference current trim, codes per trim table.
// - Reset clears reference current trim to zero.
// - Two-bit write-only recopy trim for bridges one and two.
// - Reset clears the lower bridge pair recopy trim.
// - Three-bit write-only recopy trim for bridges three and four.
// - Reset clears the upper bridge pair recopy trim.
// - Valid frame has exactly 16 clock edges; write lands on select rise.
`ifndef ATB_PARAMS_SVH
`define ATB_PARAMS_SVH

`define ATB_ADDR_TEST      5'h0E
`define ATB_ADDR_TRIM1     5'h0F
`define ATB_ADDR_TRIM2     5'h10

`define ATB_FRAME_EDGES    5'h10
`define ATB_PARITY_EDGE    5'h07

`define ATB_OC_SEL_MSB     7
`define ATB_OC_SEL_LSB     6
`define ATB_REF_MSB        3
`define ATB_REF_LSB        0
`define ATB_LOW_MSB        7
`define ATB_LOW_LSB        6
`define ATB_UP_MSB         5
`define ATB_UP_LSB         3

`define ATB_OC_SEL_RST     2'h0
`define ATB_REF_RST        4'h0
`define ATB_LOW_RST        2'h0
`define ATB_UP_RST         3'h0

`define ATB_CLK_MHZ        125
`define ATB_OC_T0_US       950
`define ATB_OC_T1_US       536
`define ATB_OC_T2_US       234
`define ATB_OC_T3_US       78

`endif

/* atb_pkg.sv */
/*
 * Types shared by the analog trim register bank.
 * Assumes atb_params.svh supplies the numeric constants.
 */
package atb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_COMMIT = 2'h3
  } atb_frame_st_t;

  typedef logic [16:0] atb_cnt_t;

endpackage

/* atb_spi_master.sv */
/* spi master model of the embedded controller facing the trim bank.
   assumes the bank's core_clk; drives on the falling core edge. */
`timescale 1ns/1ps
module atb_spi_master (
  input  wire logic core_clk, // core clock
  input  wire logic spiMiso,  // data from bank
  output logic      spiSclk,  // serial clock
  output logic      spiSsN,   // slave select, low
  output logic      spiMosi   // data to bank
);
  // --------
  // frame driver
  // --------
  localparam int HALF = 4; // bank needs >=3 core cycles a phase
  initial begin
    spiSclk = 1'b0;
    spiSsN = 1'b1;
    spiMosi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // edges other than 16 or badPar give a frame the bank must void
  task automatic xfer(input logic [4:0] a, input logic rw,
      input logic [7:0] d, input int e, input logic badPar,
      output logic [15:0] rx);
    logic [15:0] w;
    rx = 16'h0000;
    if (!rw && a == 5'h0E) return;
    w = {a, rw, ^{rw, a} ^ badPar, 1'b0, d};
    if (a == 5'h0F) w[5:4] = 2'h0;
    spiSsN = 1'b0;
    wt(2);
    for (int i = 0; i < e; i++) begin
      spiSclk = 1'b1;
      spiMosi = w[15 - (i % 16)];
      wt(HALF);
      rx = {rx[14:0], spiMiso};
      spiSclk = 1'b0;
      wt(HALF);
    end
    spiSsN = 1'b1;
    spiMosi = ~spiMosi; // released line shows no stale bit
    wt(3);
  endtask
endmodule

/* atb_trim_bank.sv */
/*
 * Analog trim register bank reached over the internal 16-bit serial link.
 * Holds the overcurrent filter select, the reference current trim and the
 * two half-bridge recopy trims, and filters the supply overcurrent signal.
 * Assumes serial pins are synchronous to core_clk and slower than it.
 */
`timescale 1ns/1ps
`include "atb_params.svh"

module atb_trim_bank #(
  parameter int OC_CYC0 = `ATB_OC_T0_US * `ATB_CLK_MHZ,
  parameter int OC_CYC1 = `ATB_OC_T1_US * `ATB_CLK_MHZ,
  parameter int OC_CYC2 = `ATB_OC_T2_US * `ATB_CLK_MHZ,
  parameter int OC_CYC3 = `ATB_OC_T3_US * `ATB_CLK_MHZ
) (
  input  wire logic       core_clk,          // core clock
  input  wire logic       rst,               // async reset, high
  input  wire logic       spiSclk,           // serial clock
  input  wire logic       spiSsN,            // slave select, low
  input  wire logic       spiMosi,           // serial data in
  input  wire logic [7:0] statusByte,        // system status byte
  input  wire logic       supplyOcRaw,       // raw overcurrent level
  output logic            spiMiso,           // serial data out
  output logic            spiMisoOe,         // miso drive enable
  output logic [1:0]      supplyOcFilterSel, // filter delay select
  output logic [3:0]      refCurrentTrim,    // reference trim
  output logic [1:0]      lowerPairTrim,     // bridges 1..2 trim
  output logic [2:0]      upperPairTrim,     // bridges 3..4 trim
  output logic            supplyOcShutdown   // filtered overcurrent
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic atb_pkg::atb_cnt_t ocLimit(input logic [1:0] sel);
    case (sel)
      2'h0:    ocLimit = atb_pkg::atb_cnt_t'(OC_CYC0);
      2'h1:    ocLimit = atb_pkg::atb_cnt_t'(OC_CYC1);
      2'h2:    ocLimit = atb_pkg::atb_cnt_t'(OC_CYC2);
      default: ocLimit = atb_pkg::atb_cnt_t'(OC_CYC3);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  atb_pkg::atb_frame_st_t st_q, st_d;
  logic        sclkPrev_q, sclkPrev_d;
  logic [4:0]  fallCnt_q, fallCnt_d;
  logic [4:0]  riseCnt_q, riseCnt_d;
  logic [15:0] rxShift_q, rxShift_d;
  logic [15:0] txFrame_q, txFrame_d;
  logic        miso_q, miso_d;
  logic        misoOe_q, misoOe_d;
  logic        commit;
  logic        sclkFall;
  logic        sclkRise;
  logic [4:0]  rxAddr;
  logic        rxRead;
  logic        parityOk;
  logic [7:0]  readData;

  assign sclkFall = sclkPrev_q & ~spiSclk;
  assign sclkRise = ~sclkPrev_q & spiSclk;
  assign rxAddr   = rxShift_q[15:11];
  assign rxRead   = rxShift_q[10];
  // even parity covers the read/write bit, the address and the parity bit
  assign parityOk = ~^rxShift_q[15:9];
  // write-only fields read as zero; after seven bits the address is [6:2]
  assign readData = (rxShift_d[6:2] == `ATB_ADDR_TRIM1) ?
                    {supplyOcFilterSel, 6'h00} : 8'h00;
  assign commit   = (st_q == atb_pkg::ST_ACTIVE) && spiSsN;

  always_comb begin
    st_d       = st_q;
    sclkPrev_d = spiSclk;
    fallCnt_d  = fallCnt_q;
    riseCnt_d  = riseCnt_q;
    rxShift_d  = rxShift_q;
    txFrame_d  = txFrame_q;
    miso_d     = miso_q;
    misoOe_d   = 1'b0;
    case (st_q)
      atb_pkg::ST_IDLE: begin
        if (!spiSsN) begin
          st_d      = atb_pkg::ST_ACTIVE;
          fallCnt_d = 5'h00;
          riseCnt_d = 5'h00;
          txFrame_d = {statusByte, 8'h00};
          miso_d    = 1'b0;
          misoOe_d  = 1'b1;
        end
      end
      atb_pkg::ST_ACTIVE: begin
        misoOe_d = ~spiSsN;
        if (spiSsN) begin
          st_d = atb_pkg::ST_COMMIT;
        end else begin
          if (sclkRise && riseCnt_q < `ATB_FRAME_EDGES) begin
            miso_d    = txFrame_q[4'hF - riseCnt_q[3:0]];
            riseCnt_d = riseCnt_q + 5'h01;
          end
          if (sclkFall) begin
            if (fallCnt_q != 5'h1F) begin
              fallCnt_d = fallCnt_q + 5'h01;
            end
            rxShift_d = {rxShift_q[14:0], spiMosi};
            // read data is captured as the parity bit arrives
            if (fallCnt_q == `ATB_PARITY_EDGE - 5'h01) begin
              txFrame_d[7:0] = readData;
            end
          end
        end
      end
      atb_pkg::ST_COMMIT: begin
        st_d = atb_pkg::ST_IDLE;
      end
      default: begin
        st_d = atb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q       <= atb_pkg::ST_IDLE;
      sclkPrev_q <= 1'b0;
      fallCnt_q  <= 5'h00;
      riseCnt_q  <= 5'h00;
      rxShift_q  <= 16'h0000;
      txFrame_q  <= 16'h0000;
      miso_q     <= 1'b0;
      misoOe_q   <= 1'b0;
    end else begin
      st_q       <= st_d;
      sclkPrev_q <= sclkPrev_d;
      fallCnt_q  <= fallCnt_d;
      riseCnt_q  <= riseCnt_d;
      rxShift_q  <= rxShift_d;
      txFrame_q  <= txFrame_d;
      miso_q     <= miso_d;
      misoOe_q   <= misoOe_d;
    end
  end

  assign spiMiso   = miso_q;
  assign spiMisoOe = misoOe_q;

  // ----------------------------------------------------------------
  // trim registers
  // ----------------------------------------------------------------
  logic [1:0] ocSel_q, ocSel_d;
  logic [3:0] refTrim_q, refTrim_d;
  logic [1:0] lowTrim_q, lowTrim_d;
  logic [2:0] upTrim_q, upTrim_d;
  logic       wrValid;

  // short, long or misframed transfers and bad parity are dropped
  assign wrValid = commit && fallCnt_q == `ATB_FRAME_EDGES
                   && !rxRead && parityOk;

  always_comb begin
    ocSel_d   = ocSel_q;
    refTrim_d = refTrim_q;
    lowTrim_d = lowTrim_q;
    upTrim_d  = upTrim_q;
    if (wrValid && rxAddr == `ATB_ADDR_TRIM1) begin
      ocSel_d   = rxShift_q[`ATB_OC_SEL_MSB:`ATB_OC_SEL_LSB];
      refTrim_d = rxShift_q[`ATB_REF_MSB:`ATB_REF_LSB];
    end
    if (wrValid && rxAddr == `ATB_ADDR_TRIM2) begin
      lowTrim_d = rxShift_q[`ATB_LOW_MSB:`ATB_LOW_LSB];
      upTrim_d  = rxShift_q[`ATB_UP_MSB:`ATB_UP_LSB];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ocSel_q   <= `ATB_OC_SEL_RST;
      refTrim_q <= `ATB_REF_RST;
      lowTrim_q <= `ATB_LOW_RST;
      upTrim_q  <= `ATB_UP_RST;
    end else begin
      ocSel_q   <= ocSel_d;
      refTrim_q <= refTrim_d;
      lowTrim_q <= lowTrim_d;
      upTrim_q  <= upTrim_d;
    end
  end

  assign supplyOcFilterSel = ocSel_q;
  assign refCurrentTrim    = refTrim_q;
  assign lowerPairTrim     = lowTrim_q;
  assign upperPairTrim     = upTrim_q;

  // ----------------------------------------------------------------
  // overcurrent filter
  // ----------------------------------------------------------------
  atb_pkg::atb_cnt_t ocCnt_q, ocCnt_d;
  logic              ocShut_q, ocShut_d;

  // a glitch shorter than the selected delay never trips the output
  always_comb begin
    ocCnt_d  = ocCnt_q;
    ocShut_d = ocShut_q;
    if (!supplyOcRaw) begin
      ocCnt_d  = '0;
      ocShut_d = 1'b0;
    end else if (ocCnt_q >= ocLimit(ocSel_q) - 17'h00001) begin
      ocShut_d = 1'b1;
    end else begin
      ocCnt_d = ocCnt_q + 17'h00001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ocCnt_q  <= '0;
      ocShut_q <= 1'b0;
    end else begin
      ocCnt_q  <= ocCnt_d;
      ocShut_q <= ocShut_d;
    end
  end

  assign supplyOcShutdown = ocShut_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_trim1_write: assert property (wrValid && rxAddr == `ATB_ADDR_TRIM1
      |=> ocSel_q == $past(rxShift_q[7:6])
          && refTrim_q == $past(rxShift_q[3:0]))
    else $error("trim1 write not stored");
  a_trim2_write: assert property (wrValid && rxAddr == `ATB_ADDR_TRIM2
      |=> lowTrim_q == $past(rxShift_q[7:6])
          && upTrim_q == $past(rxShift_q[5:3]))
    else $error("trim2 write not stored");
  a_bad_count: assert property (commit && fallCnt_q != `ATB_FRAME_EDGES
      |=> $stable(ocSel_q) && $stable(refTrim_q)
          && $stable(lowTrim_q) && $stable(upTrim_q))
    else $error("misframed transfer changed a register");
  a_no_mid_write: assert property (!spiSsN |=> $stable(refTrim_q))
    else $error("register changed inside a frame");
  a_trim2_reads: assert property (sclkFall && fallCnt_q == 5'h06
      && st_q == atb_pkg::ST_ACTIVE && rxShift_d[6:2] == `ATB_ADDR_TRIM2
      |=> txFrame_q[7:0] == 8'h00)
    else $error("write-only register read not zero");
  // only sound while every filter limit is at least eight cycles
  a_oc_trip: assert property (!supplyOcRaw ##1 supplyOcRaw [*8]
      |-> !supplyOcShutdown)
    else $error("overcurrent tripped too early");
  a_oc_clear: assert property (!supplyOcRaw |=> !supplyOcShutdown)
    else $error("shutdown held without overcurrent");
  a_miso_off: assert property (spiSsN && st_q != atb_pkg::ST_IDLE
      |=> !spiMisoOe)
    else $error("miso driven after select release");
  a_reset_vals: assert property ($fell(rst)
      |-> ocSel_q == 2'h0 && refTrim_q == 4'h0
          && lowTrim_q == 2'h0 && upTrim_q == 3'h0)
    else $error("trim not cleared by reset");

  c_trim1_write: cover property (wrValid && rxAddr == `ATB_ADDR_TRIM1);
  c_trim2_write: cover property (wrValid && rxAddr == `ATB_ADDR_TRIM2);
  c_short_frame: cover property (commit && fallCnt_q < `ATB_FRAME_EDGES);
  c_oc_trip:     cover property ($rose(supplyOcShutdown));

endmodule
